// *** verilog/sacc_pkg.sv ***
/*
 * sacc_pkg: constants and types for the converter sequencing block.
 * Assumes one system clock and that every configuration input is synchronous to it.
 */
package sacc_pkg;

    // ******************************************************************
    // widths
    // ******************************************************************
    localparam int SACC_RES_W = 12;
    localparam int SACC_CNT_W = 6;
    localparam int SACC_DIV_W = 4;
    localparam int SACC_TIMERS = 6;

    // ******************************************************************
    // start source codes (timers take the remaining codes upward)
    // ******************************************************************
    localparam logic [2:0] SACC_SRC_SOFTWARE = 3'h0;
    localparam logic [2:0] SACC_SRC_EXT_PIN = 3'h1;
    localparam logic [2:0] SACC_SRC_TIMER0 = 3'h2;

    // ******************************************************************
    // clock divider codes
    // ******************************************************************
    localparam logic [2:0] SACC_DIV_BY1 = 3'h0;
    localparam logic [2:0] SACC_DIV_BY2 = 3'h1;
    localparam logic [2:0] SACC_DIV_BY4 = 3'h2;
    localparam logic [2:0] SACC_DIV_BY8 = 3'h3;
    localparam logic [3:0] SACC_TERM_BY1 = 4'h0;
    localparam logic [3:0] SACC_TERM_BY2 = 4'h1;
    localparam logic [3:0] SACC_TERM_BY4 = 4'h3;
    localparam logic [3:0] SACC_TERM_BY8 = 4'h7;
    localparam logic [3:0] SACC_TERM_BY16 = 4'hf;

    // ******************************************************************
    // timing counts, in converter clock periods, and the unity gain code
    // ******************************************************************
    localparam logic [5:0] SACC_ACQ_MIN = 6'h03;
    localparam logic [5:0] SACC_ACQ_GAIN_EXTRA = 6'h28;
    localparam logic [5:0] SACC_CONV_LAST = 6'h0c;
    localparam logic [5:0] SACC_PWRUP_DEFAULT = 6'h04;
    localparam logic [2:0] SACC_GAIN_ONE = 3'h0;

    // ******************************************************************
    // reset values
    // ******************************************************************
    localparam logic [11:0] SACC_RESULT_RST = 12'h000;
    localparam logic SACC_PULLUP_RST = 1'b1;
    localparam logic SACC_PIN_CONV_RST = 1'b0;

    // ******************************************************************
    // sequencer states
    // ******************************************************************
    typedef enum logic [1:0] {
        SACC_ST_OFF = 2'b00,
        SACC_ST_PWRUP = 2'b01,
        SACC_ST_ACQ = 2'b10,
        SACC_ST_CONV = 2'b11
    } sacc_state_t;

endpackage : sacc_pkg

// *** verilog/sacc_clk_div.sv ***
/*
 * sacc_clk_div: makes a one-cycle tick per converter clock period.
 * Assumes the divider code may change at any time; the count simply restarts its wrap.
 */
`timescale 1ns/1ns
module sacc_clk_div
    import sacc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // divider code
    input wire logic [2:0] i_clock_divider_field,
    // converter clock falling-edge tick
    output logic o_tick
);

    logic [SACC_DIV_W-1:0] cnt_q;
    logic [SACC_DIV_W-1:0] cnt_d;
    logic [SACC_DIV_W-1:0] term;
    logic tick_d;
    logic tick_q;

    // divider code to terminal count; reserved codes fall to divide by sixteen
    function automatic logic [SACC_DIV_W-1:0] div_term(input logic [2:0] code);
        case (code)
            SACC_DIV_BY1: div_term = SACC_TERM_BY1;
            SACC_DIV_BY2: div_term = SACC_TERM_BY2;
            SACC_DIV_BY4: div_term = SACC_TERM_BY4;
            SACC_DIV_BY8: div_term = SACC_TERM_BY8;
            default: div_term = SACC_TERM_BY16;
        endcase
    endfunction : div_term

    // wrap counter; the tick is registered so it is a clean flop output
    always_comb begin
        term = div_term(i_clock_divider_field);
        tick_d = (cnt_q >= term);
        cnt_d = tick_d ? '0 : cnt_q + 4'h1;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;

endmodule : sacc_clk_div

// *** verilog/sacc_ctrl.sv ***
/*
 * sacc_ctrl: start-source selection, power/acquire/convert sequencing, SAR bit
 * trials, result coding and status flags for a 12-bit converter.
 * Assumes the analog side answers i_comparator for the trial code it is shown
 * before the next converter tick, and all inputs are synchronous to i_clk.
 */
// What this block does
// - start source field picks timers, external pin or software start bit
// - edge mode bit alone picks single or dual edge for any source
// - dual edge: rise powers up and acquires, fall samples and converts
// - single edge from off: one rise runs power-up, acquire, convert
// - single edge while powered: acquire until rise, then convert at the next tick once minimum acquisition is met
// - without auto shutdown, track again at thirteenth converter tick
// - gain above one adds forty converter cycles of acquisition
// - acquisition never shorter than three converter cycles
// - eight differential pairs: channel n uses inputs 2n and 2n+1
// - differential enable sets differential mode; channel field picks pair
// - polarity bit picks unipolar or bipolar differential range
// - unipolar negative input gives code zero
// - twelve-bit result, straight binary unipolar, two's complement bipolar
// - external pin starts on rise or fall as the edge mode says
// - shared pin defaults to digital I/O with pullup after reset
// - result latched when busy falls
// - data ready set on completion, cleared by reading result
// - ready still set when busy falls sets overrun; status read clears
// - converter clock divides system clock by 1,2,4,8,16; reserved 16
`timescale 1ns/1ns
module sacc_ctrl
    import sacc_pkg::*;
#(
    parameter int N_TIMERS = SACC_TIMERS,
    parameter logic [5:0] PWRUP_TICKS = SACC_PWRUP_DEFAULT
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // configuration
    input wire logic [2:0] i_start_source_select,
    input wire logic i_edge_mode_select,
    input wire logic i_auto_shutdown_enable,
    input wire logic i_differential_enable,
    input wire logic [2:0] i_channel_select,
    input wire logic i_polarity_select,
    input wire logic [2:0] i_amp_gain_field,
    input wire logic [2:0] i_clock_divider_field,
    // start sources
    input wire logic i_software_start,
    input wire logic [N_TIMERS-1:0] i_timer_start,
    input wire logic i_external_start_pin,
    // shared pin function
    input wire logic i_port0_bit4_conv_select,
    input wire logic i_port0_bit4_pullup_select,
    output logic o_port0_bit4_conv_mode,
    output logic o_port0_bit4_pullup,
    // analog front end
    input wire logic i_comparator,
    input wire logic i_diff_negative,
    output logic o_converter_power,
    output logic o_track,
    output logic o_differential_mode,
    output logic [3:0] o_mux_pos,
    output logic [3:0] o_mux_neg,
    output logic [SACC_RES_W-1:0] o_sar_trial,
    // result and status
    input wire logic i_result_read,
    input wire logic i_status_read,
    output logic o_converter_busy,
    output logic [SACC_RES_W-1:0] o_result,
    output logic o_data_ready_flag,
    output logic o_overrun_flag
);

    // ******************************************************************
    // converter clock
    // ******************************************************************
    logic tick;

    sacc_clk_div u_div (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_clock_divider_field(i_clock_divider_field),
        .o_tick(tick)
    );

    // ******************************************************************
    // shared pin function
    // ******************************************************************
    logic pin_conv_q, pin_conv_d;
    logic pullup_q, pullup_d;

    // reset leaves the pin as plain digital I/O with the pullup on
    always_comb begin
        pin_conv_d = i_port0_bit4_conv_select;
        pullup_d = i_port0_bit4_pullup_select;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_conv_q <= SACC_PIN_CONV_RST;
            pullup_q <= SACC_PULLUP_RST;
        end else begin
            pin_conv_q <= pin_conv_d;
            pullup_q <= pullup_d;
        end
    end

    // ******************************************************************
    // start source selection and edge detection
    // ******************************************************************
    logic src_lvl;
    logic src_prev_q, src_prev_d;
    logic rise, fall;
    logic [2:0] timer_idx;

    // the pin only counts as a start source once its conversion function is on
    always_comb begin
        timer_idx = i_start_source_select - SACC_SRC_TIMER0;
        src_lvl = 1'b0;
        case (i_start_source_select)
            SACC_SRC_SOFTWARE: src_lvl = i_software_start;
            SACC_SRC_EXT_PIN: src_lvl = i_external_start_pin & pin_conv_q;
            default: begin
                if (int'(timer_idx) < N_TIMERS) begin
                    src_lvl = i_timer_start[timer_idx];
                end
            end
        endcase
        src_prev_d = src_lvl;
        rise = src_lvl & ~src_prev_q;
        fall = ~src_lvl & src_prev_q;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_prev_d;
        end
    end

    // ******************************************************************
    // sequencer
    // ******************************************************************
    sacc_state_t state_q, state_d;
    logic [SACC_CNT_W-1:0] cnt_q, cnt_d;
    logic [SACC_CNT_W-1:0] acq_len;
    logic pend_q, pend_d;
    logic [SACC_RES_W-1:0] code_q, code_d;
    logic neg_q, neg_d;
    logic [SACC_RES_W-1:0] bit_mask;
    logic conv_start, conv_done;
    logic req;
    logic [SACC_RES_W-1:0] coded;

    // gain above one stretches acquisition so the amplifier can settle
    always_comb begin
        acq_len = (i_amp_gain_field != SACC_GAIN_ONE) ?
            SACC_ACQ_MIN + SACC_ACQ_GAIN_EXTRA : SACC_ACQ_MIN;
    end

    // a request is the rise in single edge, the fall in dual edge
    always_comb begin
        req = i_edge_mode_select ? fall : rise;
        state_d = state_q;
        cnt_d = cnt_q;
        pend_d = pend_q;
        code_d = code_q;
        neg_d = neg_q;
        conv_start = 1'b0;
        conv_done = 1'b0;
        bit_mask = 12'h800 >> cnt_q[3:0];
        case (state_q)
            SACC_ST_OFF: begin
                // any rise wakes the converter; single edge also queues a conversion
                if (rise) begin
                    state_d = SACC_ST_PWRUP;
                    cnt_d = '0;
                    pend_d = ~i_edge_mode_select;
                end
            end
            SACC_ST_PWRUP: begin
                if (req) begin
                    pend_d = 1'b1;
                end
                if (tick) begin
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q + 6'h01 >= PWRUP_TICKS) begin
                        state_d = SACC_ST_ACQ;
                        cnt_d = '0;
                    end
                end
            end
            SACC_ST_ACQ: begin
                // a request early in acquisition waits for the minimum time
                if (req) begin
                    pend_d = 1'b1;
                end
                if (tick) begin
                    if ((pend_q || req) && cnt_q >= acq_len) begin
                        conv_start = 1'b1;
                        state_d = SACC_ST_CONV;
                        cnt_d = '0;
                        pend_d = 1'b0;
                        code_d = '0;
                        neg_d = i_diff_negative;
                    end else if (cnt_q != '1) begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
            end
            SACC_ST_CONV: begin
                if (req) begin
                    pend_d = 1'b1;
                end
                if (tick) begin
                    if (cnt_q == SACC_CONV_LAST) begin
                        // thirteenth tick: hold ends, result is final
                        conv_done = 1'b1;
                        cnt_d = '0;
                        state_d = i_auto_shutdown_enable ? SACC_ST_OFF : SACC_ST_ACQ;
                        if (i_auto_shutdown_enable) begin
                            pend_d = 1'b0;
                        end
                    end else begin
                        cnt_d = cnt_q + 6'h01;
                        if (i_comparator) begin
                            code_d = code_q | bit_mask;
                        end
                    end
                end
            end
            default: begin
                state_d = SACC_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= SACC_ST_OFF;
            cnt_q <= '0;
            pend_q <= 1'b0;
            code_q <= '0;
            neg_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            code_q <= code_d;
            neg_q <= neg_d;
        end
    end

    // ******************************************************************
    // front-end outputs and result coding
    // ******************************************************************
    logic power_q, track_q, busy_q, diff_q;
    logic [3:0] mux_pos_q, mux_neg_q;
    logic [SACC_RES_W-1:0] trial_q, trial_d;
    logic [SACC_RES_W-1:0] result_q, result_d;
    logic ready_q, ready_d, ovr_q, ovr_d;

    // raw SAR code is offset binary; bipolar flips the top bit, unipolar clamps below zero
    always_comb begin
        if (i_differential_enable && i_polarity_select) begin
            coded = {~code_d[11], code_d[10:0]};
        end else begin
            coded = neg_q ? '0 : code_d;
        end
        trial_d = (state_d == SACC_ST_CONV) ? (code_d | (12'h800 >> cnt_d[3:0])) : '0;
        result_d = conv_done ? coded : result_q;
        // set wins over the read that clears it
        ready_d = conv_done | (ready_q & ~i_result_read);
        ovr_d = (conv_done & ready_q) | (ovr_q & ~i_status_read);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            power_q <= 1'b0;
            track_q <= 1'b0;
            busy_q <= 1'b0;
            diff_q <= 1'b0;
            mux_pos_q <= 4'h0;
            mux_neg_q <= 4'h1;
            trial_q <= '0;
            result_q <= SACC_RESULT_RST;
            ready_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            power_q <= (state_d != SACC_ST_OFF);
            track_q <= (state_d == SACC_ST_ACQ);
            busy_q <= (state_d == SACC_ST_CONV);
            diff_q <= i_differential_enable;
            mux_pos_q <= {i_channel_select, 1'b0};
            mux_neg_q <= {i_channel_select, 1'b1};
            trial_q <= trial_d;
            result_q <= result_d;
            ready_q <= ready_d;
            ovr_q <= ovr_d;
        end
    end

    assign o_port0_bit4_conv_mode = pin_conv_q;
    assign o_port0_bit4_pullup = pullup_q;
    assign o_converter_power = power_q;
    assign o_track = track_q;
    assign o_differential_mode = diff_q;
    assign o_mux_pos = mux_pos_q;
    assign o_mux_neg = mux_neg_q;
    assign o_sar_trial = trial_q;
    assign o_converter_busy = busy_q;
    assign o_result = result_q;
    assign o_data_ready_flag = ready_q;
    assign o_overrun_flag = ovr_q;

    // ******************************************************************
    // checks
    // ******************************************************************
    // acquisition ticks counted apart from cnt_q, so the launch check trusts no sequencer count
    logic [SACC_CNT_W:0] acq_seen_q, acq_seen_d;
    always_comb begin
        acq_seen_d = (state_q != SACC_ST_ACQ) ? '0 : acq_seen_q + {6'h00, tick & ~(&acq_seen_q)};
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            acq_seen_q <= '0;
        end else begin
            acq_seen_q <= acq_seen_d;
        end
    end

    sequence busy_end_s;
        $fell(busy_q);
    endsequence

    sequence conv_launch_s;
        (state_q == SACC_ST_ACQ) && conv_start;
    endsequence

    ready_set_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        busy_end_s |-> ready_q) else $error("ready not set at end of conversion");
    result_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        busy_q && $past(busy_q) |-> $stable(result_q)) else $error("result moved while busy");
    overrun_set_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        conv_done && ready_q |=> ovr_q) else $error("overrun missed");
    ready_clear_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_result_read && !conv_done |=> !ready_q) else $error("read did not clear ready");
    uni_clamp_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        conv_done && neg_q && !(i_differential_enable && i_polarity_select)
        |=> result_q == 12'h000) else $error("negative unipolar not zero");
    min_acq_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        conv_launch_s |-> acq_seen_q >= {1'b0, acq_len}) else $error("acquisition too short");
    conv_len_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        busy_end_s |-> $past(cnt_q) == SACC_CONV_LAST && cnt_q == 6'h00 && $past(busy_q))
        else $error("conversion length wrong");
    shutdown_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        conv_done && i_auto_shutdown_enable |=> !power_q && !track_q)
        else $error("no shutdown after conversion");
    retrack_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        conv_done && !i_auto_shutdown_enable |=> track_q && power_q)
        else $error("no return to acquisition");
    wake_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == SACC_ST_OFF) && rise |=> power_q ##1 power_q)
        else $error("start edge did not power up");
    pin_gate_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_start_source_select == SACC_SRC_EXT_PIN) && !pin_conv_q |-> !src_lvl)
        else $error("pin started while in digital mode");

endmodule : sacc_ctrl

// *** dv/sacc_analog_model.sv ***
/*
 * sacc_analog_model: differential pair mux and comparator behind the sequencer.
 * Assumes the trial code is held steady between converter ticks.
 */
`timescale 1ns/1ns
module sacc_analog_model (
    // sequencer side
    input wire logic [11:0] i_sar_trial,
    input wire logic [3:0] i_mux_pos,
    input wire logic [3:0] i_mux_neg,
    // bench side: one target code per pair
    input wire logic [7:0][11:0] i_pair_code,
    input wire logic i_negative,
    // answers
    output logic o_comparator,
    output logic o_diff_negative
);
    // ******************************************************************
    // comparator
    // ******************************************************************
    logic pair_ok;
    // a mispaired input reads as zero volts, so a bad pairing shows in the result
    assign pair_ok = ({i_mux_pos[0], i_mux_neg} == {1'b0, i_mux_pos[3:1], 1'b1});
    assign o_comparator = pair_ok && (i_sar_trial <= i_pair_code[i_mux_pos[3:1]]);
    assign o_diff_negative = i_negative;
endmodule : sacc_analog_model

// *** dv/sacc_ctrl_tb_top.sv ***
/*
 * sacc_ctrl_tb_top: directed bench for the converter sequencer.
 * Assumes the analog model answers the trial code without delay.
 */
`timescale 1ns/1ns
module sacc_ctrl_tb_top;
    import sacc_pkg::*;
    // ******************************************************************
    // signals
    // ******************************************************************
    logic clk, arst_n, edge_md, asd, diff, pol, sw, pin, conv_sel, pull_sel;
    logic res_rd, st_rd, neg, cmp, dneg, cmode, pull, pwr, track, dmode, busy, ready, ovr;
    logic [2:0] sel, ch, gain, div;
    logic [5:0] tmr;
    logic [7:0][11:0] codes;
    logic [3:0] mpos, mneg;
    logic [11:0] trial, result;
    int bad_count, n_compared, t_start, t_busy, t0, d;

    sacc_ctrl #(.N_TIMERS(6), .PWRUP_TICKS(SACC_PWRUP_DEFAULT)) DUT (
        .i_clk(clk), .i_arst_n(arst_n), .i_start_source_select(sel),
        .i_edge_mode_select(edge_md), .i_auto_shutdown_enable(asd),
        .i_differential_enable(diff), .i_channel_select(ch), .i_polarity_select(pol),
        .i_amp_gain_field(gain), .i_clock_divider_field(div), .i_software_start(sw),
        .i_timer_start(tmr), .i_external_start_pin(pin), .i_port0_bit4_conv_select(conv_sel),
        .i_port0_bit4_pullup_select(pull_sel), .o_port0_bit4_conv_mode(cmode),
        .o_port0_bit4_pullup(pull), .i_comparator(cmp), .i_diff_negative(dneg),
        .o_converter_power(pwr), .o_track(track), .o_differential_mode(dmode),
        .o_mux_pos(mpos), .o_mux_neg(mneg), .o_sar_trial(trial), .i_result_read(res_rd),
        .i_status_read(st_rd), .o_converter_busy(busy), .o_result(result),
        .o_data_ready_flag(ready), .o_overrun_flag(ovr)
    );

    sacc_analog_model model (
        .i_sar_trial(trial), .i_mux_pos(mpos), .i_mux_neg(mneg), .i_pair_code(codes),
        .i_negative(neg), .o_comparator(cmp), .o_diff_negative(dneg)
    );

    // ******************************************************************
    // tasks
    // ******************************************************************
    task check(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // drives only the selected source, so a wrong pick never starts anything
    task src(input logic v);
        case (sel)
            3'h0: sw = v;
            3'h1: pin = v;
            default: tmr[sel - 3'h2] = v;
        endcase
    endtask : src

    // raise, hold up to lim cycles waiting for busy, lower, then time busy
    task conv(input int lim);
        t_start = 0;
        t_busy = 0;
        repeat (5) @(negedge clk);
        src(1'b1);
        while (busy !== 1'b1 && t_start < lim) begin
            @(negedge clk);
            t_start++;
        end
        src(1'b0);
        for (int i = 0; i < 1000 && busy !== 1'b1; i++) @(negedge clk);
        while (busy === 1'b1 && t_busy < 1000) begin
            @(negedge clk);
            t_busy++;
        end
    endtask : conv

    // ******************************************************************
    // clock, watchdog, tests
    // ******************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // whole run is under ten thousand cycles; this is fifty thousand
    initial begin
        #500000;
        bad_count++;
        end_of_test();
    end

    initial begin
        arst_n = 1'b0;
        {sel, ch, gain, div, tmr, codes} = '0;
        {sw, pin, conv_sel, res_rd, st_rd, neg, edge_md, pol} = '0;
        {asd, diff, pull_sel} = 3'h7;
        bad_count = 0;
        n_compared = 0;
        ch = 3'h5;
        repeat (6) @(posedge clk);
        check("pullup", 12'h001, pull);
        check("pin mode", 12'h000, cmode);
        check("result", 12'h000, result);
        @(negedge clk) arst_n = 1'b1;
        codes[5] = 12'habc;
        conv(1000);
        t0 = t_start;
        check("result", 12'habc, result);
        check("ready", 12'h001, ready);
        check("busy length", 12'h00d, 12'(t_busy));
        check("mux pos", 12'h00a, {8'h00, mpos});
        check("mux neg", 12'h00b, {8'h00, mneg});
        check("diff mode", 12'h001, dmode);
        repeat (4) @(negedge clk);
        check("power", 12'h000, pwr);
        conv(1000);
        check("overrun", 12'h001, ovr);
        res_rd = 1'b1;
        @(negedge clk) res_rd = 1'b0;
        check("ready", 12'h000, ready);
        st_rd = 1'b1;
        @(negedge clk) st_rd = 1'b0;
        check("overrun", 12'h000, ovr);
        // detect edge, power-up ticks, minimum acquisition ticks, launch tick
        d = int'(SACC_PWRUP_DEFAULT) + int'(SACC_ACQ_MIN) + 2;
        check("min acquisition", 12'h001, 12'(t0 >= d));
        gain = 3'h2;
        conv(1000);
        check("gain extra", 12'h028, 12'(t_start - t0));
        gain = 3'h0;
        pol = 1'b1;
        codes[5] = 12'h123;
        conv(1000);
        check("bipolar", 12'h923, result);
        // single-ended conversion keeps straight binary even with the polarity bit set
        diff = 1'b0;
        conv(1000);
        check("single ended", 12'h123, result);
        check("diff mode", 12'h000, dmode);
        diff = 1'b1;
        pol = 1'b0;
        neg = 1'b1;
        conv(1000);
        check("negative", 12'h000, result);
        neg = 1'b0;
        for (d = 0; d < 8; d++) begin
            div = d[2:0];
            conv(1000);
            check("busy length", 12'(13 * (d > 4 ? 16 : 1 << d)), 12'(t_busy));
        end
        div = 3'h0;
        sel = 3'h1;
        conv(1000);
        check("pin ignored", 12'h3e8, 12'(t_start));
        conv_sel = 1'b1;
        pull_sel = 1'b0;
        repeat (2) @(negedge clk);
        check("pin mode", 12'h001, cmode);
        check("pullup", 12'h000, pull);
        for (d = 0; d < 8; d++) begin
            sel = d[2:0];
            codes[5] = 12'h100 + 12'(d);
            conv(1000);
            check("source", 12'h100 + 12'(d), result);
        end
        // dual edge only with gain above one
        sel = 3'h1;
        {asd, gain, edge_md} = {1'b0, 3'h2, 1'b1};
        codes[5] = 12'h5a5;
        conv(100);
        check("held high", 12'h064, 12'(t_start));
        check("dual result", 12'h5a5, result);
        repeat (3) @(negedge clk);
        check("power kept", 12'h001, pwr);
        check("track again", 12'h001, track);
        {gain, edge_md} = 4'h0;
        conv(1000);
        check("powered start", 12'h001, 12'(t_start <= 4));
        end_of_test();
    end
endmodule : sacc_ctrl_tb_top
